// ===== hdl/tlb_miss_consts.vh
// Register map, field positions, codes and reset values for the translation buffer control block
`ifndef TLB_MISS_CONSTS_VH
`define TLB_MISS_CONSTS_VH

// Register byte offsets on the Avalon-MM slave
`define REG_PAGE_HIGH      8'h00
`define REG_PAGE_LOW       8'h04
`define REG_FAULT_ADDR     8'h08
`define REG_EXC_EVENT      8'h0C
`define REG_MMU_CTRL       8'h10
`define REG_SAVED_PC       8'h14
`define REG_SAVED_STATUS   8'h18
`define REG_STATUS_WORD    8'h1C
`define REG_VECTOR_BASE    8'h20
`define REG_IRQ_STATUS     8'h24
`define REG_IRQ_MASK       8'h28

// Control register fields
`define CTRL_TRANSLATE_BIT 0
`define CTRL_FLUSH_BIT     2
`define CTRL_WAY_LSB       6
`define CTRL_SINGLE_BIT    8
`define CTRL_HASH_BIT      9

// Processor status word fields
`define STAT_PRIV_BIT      30
`define STAT_BANK_BIT      29
`define STAT_BLOCK_BIT     28

// Page entry low fields
`define LOW_VALID_BIT      8
`define LOW_SIZE_BIT       4
`define LOW_SHARE_BIT      1

// Exception codes and vector offset
`define EXC_MISS_LOAD      12'h040
`define EXC_MISS_STORE     12'h060
`define MISS_VECTOR_OFS    32'h00000400

// Interrupt status bits
`define IRQ_MISS_BIT       0
`define IRQ_LOAD_BIT       1

// Reset values
`define RST_STATUS_WORD    32'h70000000
`define RST_WORD           32'h00000000

`endif

// ===== hdl/tlb_miss_unit.v
// Translation buffer with entry load, miss detection, exception capture and an Avalon-MM register slave
`timescale 1ns/10ps
`include "tlb_miss_consts.vh"

// What this block does
// - With translation disabled, no translation and no translation exceptions occur.
// - Without hashing, load writes page entry words into the replace way at VIRT_PAGE_NUM bits 16-12.
// - With hashing, the load index is VIRT_PAGE_NUM bits 16-12 XOR identifier bits 4-0.
// - A miss is when no indexed way matches the access's virtual page.
// - On a miss, faulting VIRT_PAGE_NUM goes to page entry high, full address to fault register.
// - On a miss, the event code is 040 for loads and 060 for stores.
// - On a miss, saved PC gets the instruction, or the branch when in a delay slot.
// - On a miss, status word is saved and privilege, block and bank flags set.
// - Miss with all ways valid increments the replace way, else lowest invalid way.
// - After capture, execution is redirected to vector base plus 400 hex.
// - Only miss, protection, invalid and initial-write exception types exist; this unit raises miss.
// - The buffer holds 128 entries, four ways of 32, searched in parallel.
// - A hit needs matching compared fields and a valid entry.
module tlb_miss_unit
#(
    parameter WAYS     = 4,
    parameter SETS     = 32,
    parameter IDX_W    = 5
)
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        reset_n_i,
    // Avalon-MM register slave
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Lookup request from the pipeline
    input  wire        lookup_valid_i,
    input  wire [31:0] lookup_vaddr_i,
    input  wire        lookup_store_i,
    input  wire [31:0] lookup_pc_i,
    input  wire        lookup_delay_slot_i,
    input  wire [31:0] lookup_branch_pc_i,
    // Entry load instruction from the pipeline
    input  wire        load_entry_instr_i,
    // Lookup answer
    output reg         lookup_done_o,
    output reg         lookup_hit_o,
    output reg  [31:0] phys_addr_o,
    output reg         miss_redirect_o,
    output reg  [31:0] redirect_pc_o,
    // Interrupt
    output reg         irq_o
);

    localparam ENTRIES = WAYS * SETS;

    // Architectural registers
    reg [31:0] page_entry_high_q;
    reg [31:0] page_entry_low_q;
    reg [31:0] fault_address_reg_q;
    reg [11:0] exception_event_reg_q;
    reg [31:0] saved_pc_q;
    reg [31:0] saved_status_word_q;
    reg [31:0] processor_status_word_q;
    reg [31:0] vector_base_q;
    reg        translate_enable_q;
    reg        single_space_mode_q;
    reg        index_hash_enable_q;
    reg [1:0]  replace_way_field_q;
    reg [1:0]  irq_status_q;
    reg [1:0]  irq_mask_q;

    // Entry storage, flip-flops addressed by {way, set}
    reg [21:0]        vpn_mem   [0:ENTRIES-1];
    reg [7:0]         space_identifier_mem  [0:ENTRIES-1];
    reg [28:0]        low_mem   [0:ENTRIES-1];
    reg [ENTRIES-1:0] valid_q;

    // Bus decode
    wire        bus_req    = avs_read_i | avs_write_i;
    wire        bus_wr_now = avs_write_i & ~avs_waitrequest_o;
    wire [7:0]  space_identifier_cur   = page_entry_high_q[7:0];
    wire        priv_cur   = processor_status_word_q[`STAT_PRIV_BIT];

    // Lookup index; the hash uses the current space identifier
    wire [IDX_W-1:0] lk_idx = lookup_vaddr_i[16:12] ^
                              (index_hash_enable_q ? space_identifier_cur[4:0] : {IDX_W{1'b0}});
    // Load index taken wholly from page entry high
    wire [IDX_W-1:0] ld_idx = page_entry_high_q[16:12] ^
                              (index_hash_enable_q ? space_identifier_cur[4:0] : {IDX_W{1'b0}});

    wire [WAYS-1:0] way_hit;
    wire [WAYS-1:0] way_valid;

    // All ways compared in parallel at the same index
    genvar w;
    generate
        for (w = 0; w < WAYS; w = w + 1)
        begin : g_way
            wire [6:0]  ent      = {w[1:0], lk_idx};
            wire [21:0] e_vpn    = vpn_mem[ent];
            wire [28:0] e_low    = low_mem[ent];
            wire        vpn_hi   = (e_vpn[21:2] == lookup_vaddr_i[31:12]);
            wire        vpn_lo   = e_low[`LOW_SIZE_BIT] | (e_vpn[1:0] == lookup_vaddr_i[11:10]);
            wire        space_identifier_ok  = e_low[`LOW_SHARE_BIT] | (single_space_mode_q & priv_cur) |
                                   (space_identifier_mem[ent] == space_identifier_cur);
            assign way_valid[w] = valid_q[ent];
            assign way_hit[w]   = valid_q[ent] & vpn_hi & vpn_lo & space_identifier_ok;
        end
    endgenerate

    // Physical address of the hitting way; software keeps hits unique
    reg [31:0] hit_pa;
    reg [28:0] sel_low;
    integer    k;
    always @*
    begin
        hit_pa  = 32'h00000000;
        sel_low = 29'h00000000;
        for (k = 0; k < WAYS; k = k + 1)
        begin
            if (way_hit[k])
            begin
                sel_low = low_mem[{k[1:0], lk_idx}];
            end
        end
        if (sel_low[`LOW_SIZE_BIT])
        begin
            hit_pa = {3'h0, sel_low[28:12], lookup_vaddr_i[11:0]};
        end
        else
        begin
            hit_pa = {3'h0, sel_low[28:10], lookup_vaddr_i[9:0]};
        end
    end

    // Miss only while translating; otherwise the address passes through
    wire any_hit  = |way_hit;
    wire miss_now = lookup_valid_i & translate_enable_q & ~any_hit;

    // Replacement way after a miss: lowest invalid way wins, else advance
    reg [1:0] next_way;
    integer   j;
    always @*
    begin
        next_way = replace_way_field_q + 2'h1;
        for (j = WAYS - 1; j >= 0; j = j - 1)
        begin
            if (!way_valid[j])
            begin
                next_way = j[1:0];
            end
        end
    end

    // Bus read multiplexer; unmapped offsets read as zero
    reg [31:0] rd_mux;
    always @*
    begin
        case (avs_address_i)
            `REG_PAGE_HIGH:    rd_mux = page_entry_high_q;
            `REG_PAGE_LOW:     rd_mux = page_entry_low_q;
            `REG_FAULT_ADDR:   rd_mux = fault_address_reg_q;
            `REG_EXC_EVENT:    rd_mux = {20'h00000, exception_event_reg_q};
            `REG_MMU_CTRL:     rd_mux = {22'h000000, index_hash_enable_q, single_space_mode_q,
                                         replace_way_field_q, 5'h00, translate_enable_q};
            `REG_SAVED_PC:     rd_mux = saved_pc_q;
            `REG_SAVED_STATUS: rd_mux = saved_status_word_q;
            `REG_STATUS_WORD:  rd_mux = processor_status_word_q;
            `REG_VECTOR_BASE:  rd_mux = vector_base_q;
            `REG_IRQ_STATUS:   rd_mux = {30'h00000000, irq_status_q};
            `REG_IRQ_MASK:     rd_mux = {30'h00000000, irq_mask_q};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // Bus handshake: every access is answered one cycle after it appears
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (avs_read_i & avs_waitrequest_o)
            begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // Software registers and miss capture; the miss is written last so it wins a collision
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            page_entry_high_q       <= `RST_WORD;
            page_entry_low_q        <= `RST_WORD;
            fault_address_reg_q     <= `RST_WORD;
            exception_event_reg_q   <= 12'h000;
            saved_pc_q              <= `RST_WORD;
            saved_status_word_q     <= `RST_WORD;
            processor_status_word_q <= `RST_STATUS_WORD;
            vector_base_q           <= `RST_WORD;
            translate_enable_q      <= 1'b0;
            single_space_mode_q     <= 1'b0;
            index_hash_enable_q     <= 1'b0;
            replace_way_field_q     <= 2'h0;
            irq_mask_q              <= 2'h0;
        end
        else
        begin
            if (bus_wr_now)
            begin
                case (avs_address_i)
                    `REG_PAGE_HIGH:   page_entry_high_q <= avs_writedata_i;
                    `REG_PAGE_LOW:    page_entry_low_q  <= avs_writedata_i;
                    `REG_FAULT_ADDR:  fault_address_reg_q <= avs_writedata_i;
                    `REG_EXC_EVENT:   exception_event_reg_q <= avs_writedata_i[11:0];
                    `REG_MMU_CTRL:
                    begin
                        translate_enable_q  <= avs_writedata_i[`CTRL_TRANSLATE_BIT];
                        single_space_mode_q <= avs_writedata_i[`CTRL_SINGLE_BIT];
                        index_hash_enable_q <= avs_writedata_i[`CTRL_HASH_BIT];
                        replace_way_field_q <= avs_writedata_i[`CTRL_WAY_LSB+1:`CTRL_WAY_LSB];
                    end
                    `REG_SAVED_PC:     saved_pc_q <= avs_writedata_i;
                    `REG_SAVED_STATUS: saved_status_word_q <= avs_writedata_i;
                    `REG_STATUS_WORD:  processor_status_word_q <= avs_writedata_i;
                    `REG_VECTOR_BASE:  vector_base_q <= avs_writedata_i;
                    `REG_IRQ_MASK:     irq_mask_q <= avs_writedata_i[1:0];
                    default:           page_entry_low_q <= page_entry_low_q;
                endcase
            end
            if (miss_now)
            begin
                page_entry_high_q[31:10] <= lookup_vaddr_i[31:10];
                fault_address_reg_q      <= lookup_vaddr_i;
                exception_event_reg_q    <= lookup_store_i ? `EXC_MISS_STORE : `EXC_MISS_LOAD;
                saved_pc_q               <= lookup_delay_slot_i ? lookup_branch_pc_i : lookup_pc_i;
                saved_status_word_q      <= processor_status_word_q;
                processor_status_word_q[`STAT_PRIV_BIT]  <= 1'b1;
                processor_status_word_q[`STAT_BLOCK_BIT] <= 1'b1;
                processor_status_word_q[`STAT_BANK_BIT]  <= 1'b1;
                replace_way_field_q      <= next_way;
            end
        end
    end

    // Entry storage: load writes one entry, a flush write clears every valid bit
    integer m;
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            valid_q <= {ENTRIES{1'b0}};
        end
        else if (bus_wr_now && avs_address_i == `REG_MMU_CTRL && avs_writedata_i[`CTRL_FLUSH_BIT])
        begin
            valid_q <= {ENTRIES{1'b0}};
        end
        else if (load_entry_instr_i)
        begin
            valid_q[{replace_way_field_q, ld_idx}] <= page_entry_low_q[`LOW_VALID_BIT];
        end
    end

    // Entry contents carry no reset; only valid bits need one
    always @(posedge sys_clk_i)
    begin
        if (load_entry_instr_i)
        begin
            vpn_mem[{replace_way_field_q, ld_idx}]  <= page_entry_high_q[31:10];
            space_identifier_mem[{replace_way_field_q, ld_idx}] <= page_entry_high_q[7:0];
            low_mem[{replace_way_field_q, ld_idx}]  <= page_entry_low_q[28:0];
        end
    end

    // Lookup answer; a miss never reports a hit or a usable address
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            lookup_done_o   <= 1'b0;
            lookup_hit_o    <= 1'b0;
            phys_addr_o     <= 32'h00000000;
            miss_redirect_o <= 1'b0;
            redirect_pc_o   <= 32'h00000000;
        end
        else
        begin
            lookup_done_o   <= lookup_valid_i;
            lookup_hit_o    <= lookup_valid_i & (~translate_enable_q | any_hit);
            miss_redirect_o <= miss_now;
            if (lookup_valid_i)
            begin
                phys_addr_o <= translate_enable_q ? (any_hit ? hit_pa : 32'h00000000) : lookup_vaddr_i;
            end
            if (miss_now)
            begin
                redirect_pc_o <= vector_base_q + `MISS_VECTOR_OFS;
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over a clear
    wire [1:0] irq_set = {load_entry_instr_i, miss_now};
    wire [1:0] irq_clr = (bus_wr_now && avs_address_i == `REG_IRQ_STATUS) ? avs_writedata_i[1:0] : 2'h0;
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            irq_status_q <= 2'h0;
            irq_o        <= 1'b0;
        end
        else
        begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            irq_o        <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_mask_q);
        end
    end

endmodule

// ===== testbench/tlb_miss_props.sv
// Concurrent port checks for the translation buffer control block
`timescale 1ns/10ps
module tlb_miss_props
(
    // Clock and reset
    input wire        sys_clk_i,
    input wire        reset_n_i,
    // Register slave
    input wire [7:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    // Pipeline side
    input wire        lookup_valid_i,
    input wire [31:0] lookup_vaddr_i,
    input wire        lookup_store_i,
    input wire [31:0] lookup_pc_i,
    input wire        lookup_delay_slot_i,
    input wire [31:0] lookup_branch_pc_i,
    input wire        load_entry_instr_i,
    input wire        lookup_done_o,
    input wire        lookup_hit_o,
    input wire [31:0] phys_addr_o,
    input wire        miss_redirect_o,
    input wire [31:0] redirect_pc_o,
    input wire        irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Every lookup is answered one cycle later, either hit or miss, never both
    property p_answer;
        lookup_valid_i |=> lookup_done_o && (lookup_hit_o != miss_redirect_o);
    endproperty
    a_answer: assert property (p_answer) else $error("lookup not answered");
    property p_no_answer;
        !lookup_valid_i |=> !lookup_done_o && !lookup_hit_o && !miss_redirect_o;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without lookup");
    property p_miss_zero;
        miss_redirect_o |-> lookup_done_o && !lookup_hit_o && phys_addr_o == 32'h00000000;
    endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("miss leaked an address");
    property p_phys_hold;
        !lookup_valid_i |=> $stable(phys_addr_o);
    endproperty
    a_phys_hold: assert property (p_phys_hold) else $error("address moved without lookup");
    // Slave answers one cycle after taking a request, for exactly one cycle
    property p_wait_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("bus request not answered");
    property p_wait_pulse;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_wait_idle;
        !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
    property p_read_hold;
        $changed(avs_readdata_o) |-> !avs_waitrequest_o && $past(avs_read_i);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved outside a read");

    c_miss: cover property (miss_redirect_o);
    c_hit: cover property (lookup_hit_o);
    c_irq: cover property ($rose(irq_o));
endmodule

// ===== testbench/pipe_model.sv
// Pipeline side model issuing lookups and entry loads
`timescale 1ns/10ps
module pipe_model
(
    // Clock
    input  wire         sys_clk_i,
    // Requests to the translation block
    output logic        lookup_valid_o,
    output logic [31:0] lookup_vaddr_o,
    output logic        lookup_store_o,
    output logic [31:0] lookup_pc_o,
    output logic        lookup_delay_slot_o,
    output logic [31:0] lookup_branch_pc_o,
    output logic        load_entry_o
);
    // Idle at time zero
    initial
    begin
        lookup_valid_o = 1'b0;
        {lookup_vaddr_o, lookup_pc_o, lookup_branch_pc_o} = '0;
        {lookup_store_o, lookup_delay_slot_o, load_entry_o} = '0;
    end

    // One-cycle lookup; qualifiers are scrambled once released so stale values are never trusted
    task lookup(input logic [31:0] va, input logic st, input logic [31:0] pc, input logic ds, input logic [31:0] bp);
        lookup_valid_o      <= 1'b1;
        lookup_vaddr_o      <= va;
        lookup_store_o      <= st;
        lookup_pc_o         <= pc;
        lookup_delay_slot_o <= ds;
        lookup_branch_pc_o  <= bp;
        @(posedge sys_clk_i);
        lookup_valid_o      <= 1'b0;
        lookup_vaddr_o      <= ~va;
        lookup_store_o      <= ~st;
        lookup_pc_o         <= ~pc;
        lookup_delay_slot_o <= ~ds;
        lookup_branch_pc_o  <= ~bp;
        @(posedge sys_clk_i);
    endtask

    // Handler load, then two idle slots before any translated access
    task load();
        load_entry_o <= 1'b1;
        @(posedge sys_clk_i);
        load_entry_o <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the translation buffer control block
`timescale 1ns/10ps
`include "tlb_miss_consts.vh"
module tb_top;
    logic        sys_clk_i       = 1'b0;
    logic        reset_n_i       = 1'b0;
    logic [7:0]  avs_address_i   = 8'h00;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    wire  [31:0] avs_readdata_o, lookup_vaddr_i, lookup_pc_i, lookup_branch_pc_i, phys_addr_o, redirect_pc_o;
    wire         avs_waitrequest_o, lookup_valid_i, lookup_store_i, lookup_delay_slot_i, load_entry_instr_i;
    wire         lookup_done_o, lookup_hit_o, miss_redirect_o, irq_o;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          cycles    = 0;
    int          rc        = 0;
    int          set;
    logic [31:0] seed = 32'h00000038;
    logic [31:0] vb, rd_q, va, sw, pl;
    logic [19:0] mtag [4][32];
    bit          mval [4][32];
    bit          ix   = 1'b0;

    tlb_miss_unit DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .lookup_valid_i(lookup_valid_i),
        .lookup_vaddr_i(lookup_vaddr_i), .lookup_store_i(lookup_store_i), .lookup_pc_i(lookup_pc_i),
        .lookup_delay_slot_i(lookup_delay_slot_i), .lookup_branch_pc_i(lookup_branch_pc_i),
        .load_entry_instr_i(load_entry_instr_i), .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
        .phys_addr_o(phys_addr_o), .miss_redirect_o(miss_redirect_o), .redirect_pc_o(redirect_pc_o), .irq_o(irq_o));
    pipe_model pipe (.sys_clk_i(sys_clk_i), .lookup_valid_o(lookup_valid_i), .lookup_vaddr_o(lookup_vaddr_i),
        .lookup_store_o(lookup_store_i), .lookup_pc_o(lookup_pc_i), .lookup_delay_slot_o(lookup_delay_slot_i),
        .lookup_branch_pc_o(lookup_branch_pc_i), .load_entry_o(load_entry_instr_i));

    // Clock and hang guard
    initial
    begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Avalon master: hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 40)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        rd_q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(rd_q & m, e);
    endtask

    // Miss at a fixed set, check the captured state, then run the handler and hit
    task access(input int k);
        logic [31:0] pc, bp, vh;
        bit          hit;
        int          nw;
        pc  = rnd();
        bp  = rnd();
        vh  = rnd();
        va  = {vh[31:17], 5'h0A, vh[11:0]};
        sw  = rnd() & 32'h8FFFFFFF;
        set = va[16:12] ^ (ix ? 5'h13 : 5'h00);
        hit = 1'b0;
        nw  = -1;
        for (int w = 3; w >= 0; w--)
        begin
            if (!mval[w][set])
                nw = w;
            if (mval[w][set] && mtag[w][set] === va[31:12])
                hit = 1'b1;
        end
        if (!hit)
            rc = (nw < 0) ? (rc + 1) % 4 : nw;
        wr(`REG_STATUS_WORD, sw);
        pipe.lookup(va, k[0], pc, k[1], bp);
        chk(lookup_hit_o, hit);
        chk(miss_redirect_o, !hit);
        chk(redirect_pc_o, vb + `MISS_VECTOR_OFS);
        chk(phys_addr_o, 32'h00000000);
        rd(`REG_FAULT_ADDR, '1, va);
        rd(`REG_PAGE_HIGH, 32'hFFFFFC00, va & 32'hFFFFFC00);
        rd(`REG_EXC_EVENT, 32'h00000FFF, k[0] ? `EXC_MISS_STORE : `EXC_MISS_LOAD);
        rd(`REG_SAVED_PC, '1, k[1] ? bp : pc);
        rd(`REG_SAVED_STATUS, '1, sw);
        rd(`REG_STATUS_WORD, '1, sw | 32'h70000000);
        rd(`REG_MMU_CTRL, 32'h000000C0, rc << 6);
        chk(irq_o, 1'b1);
        pl = (rnd() & 32'h1FFFF000) | 32'h00000112;
        wr(`REG_PAGE_LOW, pl);
        pipe.load();
        mtag[rc][set] = va[31:12];
        mval[rc][set] = 1'b1;
        wr(`REG_IRQ_STATUS, 32'h00000003);
        pipe.lookup(va, 1'b0, pc, 1'b0, bp);
        chk(lookup_hit_o, 1'b1);
        chk(phys_addr_o & 32'h1FFFFFFF, {pl[28:12], va[11:0]});
        chk(irq_o, 1'b0);
    endtask

    task complete_run();
        $display("Checks made: %0d, mismatches: %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        vb = rnd();
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(`REG_STATUS_WORD, '1, `RST_STATUS_WORD);
        rd(`REG_MMU_CTRL, '1, 32'h00000000);
        rd(8'h2C, '1, 32'h00000000);
        va = rnd();
        pipe.lookup(va, 1'b1, 32'h00000000, 1'b0, 32'h00000000);
        chk(lookup_hit_o, 1'b1);
        chk(miss_redirect_o, 1'b0);
        chk(phys_addr_o, va);
        wr(`REG_VECTOR_BASE, vb);
        wr(`REG_IRQ_MASK, 32'h00000001);
        wr(`REG_PAGE_HIGH, 32'h00000013);
        wr(`REG_MMU_CTRL, 32'h00000005);
        for (int k = 0; k < 6; k++)
            access(k);
        ix = 1'b1;
        rc = 0;
        mval = '{default: 1'b0};
        wr(`REG_MMU_CTRL, 32'h00000205);
        access(2);
        access(1);
        wr(`REG_IRQ_MASK, 32'h00000002);
        pipe.load();
        chk(irq_o, 1'b1);
        complete_run();
    end
endmodule

bind tlb_miss_unit tlb_miss_props u_props (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .lookup_valid_i(lookup_valid_i), .lookup_vaddr_i(lookup_vaddr_i), .lookup_store_i(lookup_store_i),
    .lookup_pc_i(lookup_pc_i), .lookup_delay_slot_i(lookup_delay_slot_i), .lookup_branch_pc_i(lookup_branch_pc_i),
    .load_entry_instr_i(load_entry_instr_i), .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
    .phys_addr_o(phys_addr_o), .miss_redirect_o(miss_redirect_o), .redirect_pc_o(redirect_pc_o), .irq_o(irq_o));
